// ===== bth_defs.vh
// constants for the bridge type-1 configuration header block
`ifndef BTH_DEFS_VH
`define BTH_DEFS_VH
// dword offsets of the header
`define BTH_OFF_CMD_STS 8'h04
`define BTH_OFF_REV_CLASS 8'h08
`define BTH_OFF_CACHE_HDR 8'h0C
`define BTH_OFF_BUS_NUM 8'h18
`define BTH_OFF_IO_SSTS 8'h1C
// command bit positions
`define BTH_CMD_PERR_EN 6
`define BTH_CMD_SERR_EN 8
`define BTH_CMD_INT_DIS 10
// status bit positions, relative to the upper half of the dword
`define BTH_STS_CAP_LIST 4
`define BTH_STS_66MHZ 5
`define BTH_STS_FBB 7
`define BTH_STS_MDPE 8
`define BTH_STS_STA 11
`define BTH_STS_RTA 12
`define BTH_STS_RMA 13
`define BTH_STS_SSE 14
`define BTH_STS_DPE 15
// fixed header values
// revision value is arbitrary and names no real part
`define BTH_REVISION 8'h5A
`define BTH_CLASS_CODE 24'h06_0400
`define BTH_HDR_TRANSPARENT 7'h01
`define BTH_HDR_NONTRANSPARENT 7'h00
`define BTH_DEVSEL_MEDIUM 2'h1
`define BTH_DEVSEL_FAST 2'h0
`define BTH_IO_ADDR32 2'h1
`define BTH_LAT_PCIX_RESET 8'h40
`define BTH_LAT_PCI_RESET 8'h00
`endif

// ===== bth_w1c_flag.v
// one write-one-to-clear status flag where a set event beats the clear
`timescale 1ns/1ns
module bth_w1c_flag (
    // clock and reset
    input wire clk,
    input wire resetn,
    // event and software clear
    input wire set_evt,
    input wire clr_req,
    // flag value
    output reg flag_reg
);
    // set wins over a clear in the same cycle so no event is lost
    always @(posedge clk) begin
        if (!resetn) begin
            flag_reg <= 1'b0;
        end else if (set_evt) begin
            flag_reg <= 1'b1;
        end else if (clr_req) begin
            flag_reg <= 1'b0;
        end
    end
endmodule // bth_w1c_flag

// ===== bth_config_header.v
// type-1 configuration header of a reversible express-to-pci bridge
`timescale 1ns/1ns
`include "bth_defs.vh"

// Functional notes
// - serr enable gates error messages or pin
// - reverse interrupt disable blocks four interrupts
// - forward primary parity flag on poison events
// - reverse primary parity flag on three events
// - devsel timing reads 00 forward, 01 reverse on primary, swapped on secondary
// - primary signaled target abort event sets flag
// - primary received target/master abort flags
// - primary signaled system error flag
// - primary detected parity error flag
// - capability list bit always reads one
// - class code bridge, no subtractive decode
// - cache line size bits 5:2 writable
// - primary latency timer reverse-only writable
// - secondary latency timer forward-only writable
// - header layout by transparency, single function
// - io base/limit report 32-bit, 4-bit fields
// - secondary fast back-to-back capable bit
// - forward secondary parity flag on three events
// - forward secondary received abort flags
// - secondary received system error flag
// - wait cycle and fast b2b read zero
// - write one clears status flags
module bth_config_header (
    // clock and reset
    input wire clk,
    input wire resetn,

    // straps, sampled every cycle after reset
    input wire reverse_mode,
    input wire pcix_mode,
    input wire nontransparent_mode,

    // configuration access port
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata_reg,

    // primary side events, forward mode
    input wire fwd_pri_poison_cpl,
    input wire fwd_pri_poison_wr,
    input wire fwd_pri_ca_sent,
    input wire fwd_pri_ca_cpl,
    input wire fwd_pri_ur_cpl,
    input wire fwd_pri_poison_rx,
    input wire fwd_err_req,

    // primary side events, reverse mode
    input wire rev_pri_rd_perr,
    input wire upstream_parity_err_n,
    input wire rev_pri_wr_active,
    input wire rev_pri_scm_perr,
    input wire rev_pri_ta_sent,
    input wire rev_pri_ta_det,
    input wire rev_pri_ma_det,
    input wire rev_pri_par_det,
    input wire rev_err_req,

    // secondary side events
    input wire fwd_sec_rd_perr,
    input wire downstream_parity_err_n,
    input wire fwd_sec_wr_active,
    input wire fwd_sec_scm_perr,
    input wire fwd_sec_ta_det,
    input wire fwd_sec_ma_det,
    input wire fwd_sec_serr_n,
    input wire rev_sec_err_msg,

    // legacy interrupt requests from the core, active low
    input wire [3:0] core_irq_n,

    // error reporting outputs
    output wire err_msg_send,
    output wire system_error_out_n,

    // legacy interrupt outputs, active low
    output wire legacy_irq_a_n,
    output wire legacy_irq_b_n,
    output wire legacy_irq_c_n,
    output wire legacy_irq_d_n,

    // control fields out to the bridge core
    output wire [7:0] upstream_bus_number,
    output wire [7:0] downstream_bus_number,
    output wire [7:0] highest_bus_number,
    output wire [3:0] io_window_base,
    output wire [3:0] io_window_limit,
    output wire [7:0] cache_line_size,
    output wire [7:0] primary_latency_timer,
    output wire [7:0] secondary_latency_timer
);

    // all storage resets to zero except the reset tracker, which resets to one;
    // the latency timers' value after reset follows the pcix strap
    // writable command bits
    reg perr_en_reg;
    reg serr_en_reg;
    reg int_dis_reg;

    // writable header fields
    reg [3:0] cls_reg;
    reg [7:0] pri_lat_reg;
    reg [7:0] sec_lat_reg;
    reg [7:0] pbus_reg;
    reg [7:0] sbus_reg;
    reg [7:0] subus_reg;
    reg [3:0] iob_reg;
    reg [3:0] iol_reg;

    // reset seen last cycle, used to load strap-dependent reset values
    reg rst_seen_reg;

    // flag map, primary: 0 parity, 1 signaled abort, 2 target abort,
    // 3 master abort, 4 system error, 5 detected parity
    // flag map, secondary: 6 parity, 7 signaled abort, 8 target abort,
    // 9 master abort, 10 received system error
    // status flags: index 0..5 primary, 6..10 secondary
    wire [10:0] flag;
    wire [10:0] flag_set;
    wire [10:0] flag_clr;

    // a write to an unmapped offset decodes to no strobe and is dropped
    // decoded write strobes per dword
    wire wr_cmd = cfg_wr && (cfg_addr == `BTH_OFF_CMD_STS);
    wire wr_hdr = cfg_wr && (cfg_addr == `BTH_OFF_CACHE_HDR);
    wire wr_bus = cfg_wr && (cfg_addr == `BTH_OFF_BUS_NUM);
    wire wr_io = cfg_wr && (cfg_addr == `BTH_OFF_IO_SSTS);

    // the mode strap picks which event set feeds each flag; events of
    // the other mode are ignored, since their side is not ours then
    // event qualification
    wire fwd = !reverse_mode;
    wire rev = reverse_mode;
    wire pri_perr_seen = !upstream_parity_err_n && rev_pri_wr_active;
    wire sec_perr_seen = !downstream_parity_err_n && fwd_sec_wr_active;

    // error request gated by serr enable
    wire fwd_err_fire = fwd && fwd_err_req && serr_en_reg;
    wire rev_err_fire = rev && rev_err_req && serr_en_reg;

    // events are one-cycle pulses; the flag cells hold them until cleared
    // primary master data parity error, gated by parity response enable
    assign flag_set[0] = perr_en_reg && ((fwd && (fwd_pri_poison_cpl || fwd_pri_poison_wr))
        || (rev && (rev_pri_rd_perr || pri_perr_seen || rev_pri_scm_perr)));
    assign flag_set[1] = (fwd && fwd_pri_ca_sent) || (rev && rev_pri_ta_sent);
    assign flag_set[2] = (fwd && fwd_pri_ca_cpl) || (rev && rev_pri_ta_det);
    assign flag_set[3] = (fwd && fwd_pri_ur_cpl) || (rev && rev_pri_ma_det);
    assign flag_set[4] = fwd_err_fire || rev_err_fire;
    assign flag_set[5] = (fwd && fwd_pri_poison_rx) || (rev && rev_pri_par_det);

    // secondary flags; reverse mode only feeds the received system error flag, from rev_sec_err_msg
    assign flag_set[6] = perr_en_reg && fwd
        && (fwd_sec_rd_perr || sec_perr_seen || fwd_sec_scm_perr);
    assign flag_set[7] = 1'b0;
    assign flag_set[8] = fwd && fwd_sec_ta_det;
    assign flag_set[9] = fwd && fwd_sec_ma_det;
    assign flag_set[10] = (fwd && !fwd_sec_serr_n) || (rev && rev_sec_err_msg);

    // only byte lane 3 carries flags, so lanes 0 to 2 never clear one
    // write-one-to-clear strobes, upper byte lanes of the status dwords
    assign flag_clr[0] = wr_cmd && cfg_be[3] && cfg_wdata[16 + `BTH_STS_MDPE];
    assign flag_clr[1] = wr_cmd && cfg_be[3] && cfg_wdata[16 + `BTH_STS_STA];
    assign flag_clr[2] = wr_cmd && cfg_be[3] && cfg_wdata[16 + `BTH_STS_RTA];
    assign flag_clr[3] = wr_cmd && cfg_be[3] && cfg_wdata[16 + `BTH_STS_RMA];
    assign flag_clr[4] = wr_cmd && cfg_be[3] && cfg_wdata[16 + `BTH_STS_SSE];
    assign flag_clr[5] = wr_cmd && cfg_be[3] && cfg_wdata[16 + `BTH_STS_DPE];
    assign flag_clr[6] = wr_io && cfg_be[3] && cfg_wdata[16 + `BTH_STS_MDPE];
    assign flag_clr[7] = wr_io && cfg_be[3] && cfg_wdata[16 + `BTH_STS_STA];
    assign flag_clr[8] = wr_io && cfg_be[3] && cfg_wdata[16 + `BTH_STS_RTA];
    assign flag_clr[9] = wr_io && cfg_be[3] && cfg_wdata[16 + `BTH_STS_RMA];
    assign flag_clr[10] = wr_io && cfg_be[3] && cfg_wdata[16 + `BTH_STS_SSE];

    // a cell per flag keeps set-over-clear priority in one place
    // one flag cell per status bit
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_flag
            bth_w1c_flag u_flag (
                .clk(clk),
                .resetn(resetn),
                .set_evt(flag_set[gi]),
                .clr_req(flag_clr[gi]),
                .flag_reg(flag[gi])
            );
        end
    endgenerate

    // the pin is active low and idles high while nothing is reported;
    // both outputs are combinational so the report leaves with the event
    // error outputs: message in forward mode, pin in reverse mode
    assign err_msg_send = fwd_err_fire;
    assign system_error_out_n = !rev_err_fire;

    // forward mode passes the core requests straight through
    // interrupt gating only applies in reverse mode
    wire irq_block = rev && int_dis_reg;
    assign legacy_irq_a_n = core_irq_n[0] | irq_block;
    assign legacy_irq_b_n = core_irq_n[1] | irq_block;
    assign legacy_irq_c_n = core_irq_n[2] | irq_block;
    assign legacy_irq_d_n = core_irq_n[3] | irq_block;

    // field outputs
    assign upstream_bus_number = pbus_reg;
    assign downstream_bus_number = sbus_reg;
    assign highest_bus_number = subus_reg;
    assign io_window_base = iob_reg;
    assign io_window_limit = iol_reg;
    assign cache_line_size = {2'b00, cls_reg, 2'b00};

    // latency timers read zero on the side where they are read-only
    assign primary_latency_timer = rev ? pri_lat_reg : 8'h00;
    assign secondary_latency_timer = fwd ? sec_lat_reg : 8'h00;

    // parity enable sits in byte 0, system error and interrupt in byte 1
    // command register writes; unsupported bits are never stored
    always @(posedge clk) begin
        if (!resetn) begin
            perr_en_reg <= 1'b0;
            serr_en_reg <= 1'b0;
            int_dis_reg <= 1'b0;
        end else if (wr_cmd) begin
            if (cfg_be[0]) begin
                perr_en_reg <= cfg_wdata[`BTH_CMD_PERR_EN];
            end
            if (cfg_be[1]) begin
                serr_en_reg <= cfg_wdata[`BTH_CMD_SERR_EN];
                int_dis_reg <= cfg_wdata[`BTH_CMD_INT_DIS] & rev;
            end
        end
    end

    // reset tracker: latency reset value depends on the pcix strap,
    // which is a port, so it is loaded on the first cycle after release
    always @(posedge clk) begin
        if (!resetn) begin
            rst_seen_reg <= 1'b1;
        end else begin
            rst_seen_reg <= 1'b0;
        end
    end

    // the strap load beats a write, so a primary latency timer write on that cycle is lost
    // cache line size and primary latency timer
    always @(posedge clk) begin
        if (!resetn) begin
            cls_reg <= 4'h0;
            pri_lat_reg <= `BTH_LAT_PCI_RESET;
        end else begin
            if (rst_seen_reg) begin
                pri_lat_reg <= pcix_mode ? `BTH_LAT_PCIX_RESET : `BTH_LAT_PCI_RESET;
            end else if (wr_hdr && cfg_be[1] && rev) begin
                pri_lat_reg <= cfg_wdata[15:8];
            end
            if (wr_hdr && cfg_be[0]) begin
                cls_reg <= cfg_wdata[5:2];
            end
        end
    end

    // bus numbers are plain storage; the core does the decoding
    // bus numbers and secondary latency timer
    always @(posedge clk) begin
        if (!resetn) begin
            pbus_reg <= 8'h00;
            sbus_reg <= 8'h00;
            subus_reg <= 8'h00;
            sec_lat_reg <= `BTH_LAT_PCI_RESET;
        end else begin
            if (wr_bus && cfg_be[0]) begin
                pbus_reg <= cfg_wdata[7:0];
            end
            if (wr_bus && cfg_be[1]) begin
                sbus_reg <= cfg_wdata[15:8];
            end
            if (wr_bus && cfg_be[2]) begin
                subus_reg <= cfg_wdata[23:16];
            end
            if (rst_seen_reg) begin
                sec_lat_reg <= pcix_mode ? `BTH_LAT_PCIX_RESET : `BTH_LAT_PCI_RESET;
            end else if (wr_bus && cfg_be[3] && fwd) begin
                sec_lat_reg <= cfg_wdata[31:24];
            end
        end
    end

    // the low bits of each byte are constants and are never stored
    // io window base and limit nibbles
    always @(posedge clk) begin
        if (!resetn) begin
            iob_reg <= 4'h0;
            iol_reg <= 4'h0;
        end else begin
            if (wr_io && cfg_be[0]) begin
                iob_reg <= cfg_wdata[7:4];
            end
            if (wr_io && cfg_be[1]) begin
                iol_reg <= cfg_wdata[15:12];
            end
        end
    end

    // images are built combinationally and registered by the read mux
    // read-back images of each dword
    wire [15:0] cmd_img;
    wire [15:0] psts_img;
    wire [15:0] ssts_img;
    wire [1:0] devsel_pri = rev ? `BTH_DEVSEL_MEDIUM : `BTH_DEVSEL_FAST;
    wire [1:0] devsel_sec = fwd ? `BTH_DEVSEL_MEDIUM : `BTH_DEVSEL_FAST;
    wire [6:0] hdr_layout = nontransparent_mode ? `BTH_HDR_NONTRANSPARENT
        : `BTH_HDR_TRANSPARENT;

    // wait cycle (bit 7) and fast b2b enable (bit 9) stay zero
    assign cmd_img = {5'h00, int_dis_reg, 1'b0, serr_en_reg, 1'b0,
        perr_en_reg, 6'h00};
    assign psts_img = {flag[5], flag[4], flag[3], flag[2], flag[1], devsel_pri,
        flag[0], (rev && !pcix_mode), 1'b0, rev, 1'b1, 4'h0};
    assign ssts_img = {1'b0, flag[10], flag[9], flag[8], flag[7], devsel_sec,
        flag[6], (fwd && !pcix_mode), 1'b0, 1'b1, 5'h00};

    // read data holds until the next read, so a slow reader sees one word
    // read mux; unmapped offsets and reserved bits return zero
    always @(posedge clk) begin
        if (!resetn) begin
            cfg_rdata_reg <= 32'h0000_0000;
        end else if (cfg_rd) begin
            case (cfg_addr)
                `BTH_OFF_CMD_STS: cfg_rdata_reg <= {psts_img, cmd_img};
                `BTH_OFF_REV_CLASS: cfg_rdata_reg <= {`BTH_CLASS_CODE, `BTH_REVISION};
                `BTH_OFF_CACHE_HDR: cfg_rdata_reg <= {8'h00, 1'b0, hdr_layout,
                    primary_latency_timer, cache_line_size};
                `BTH_OFF_BUS_NUM: cfg_rdata_reg <= {secondary_latency_timer, subus_reg,
                    sbus_reg, pbus_reg};
                `BTH_OFF_IO_SSTS: cfg_rdata_reg <= {ssts_img, iol_reg, 2'b00,
                    `BTH_IO_ADDR32, iob_reg, 2'b00, `BTH_IO_ADDR32};
                default: cfg_rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
endmodule // bth_config_header

// ===== bth_hdr_checker.sv
// port-level checker for the bridge type-1 header
`timescale 1ns/1ns
module bth_hdr_checker (
    // clock, reset and straps
    input wire clk,
    input wire resetn,
    input wire reverse_mode,
    input wire nontransparent_mode,
    // configuration access
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata_reg,
    // error and interrupt paths
    input wire fwd_err_req,
    input wire rev_err_req,
    input wire [3:0] core_irq_n,
    input wire err_msg_send,
    input wire system_error_out_n,
    input wire legacy_irq_a_n,
    input wire legacy_irq_b_n,
    input wire legacy_irq_c_n,
    input wire legacy_irq_d_n,
    // control fields
    input wire [7:0] upstream_bus_number,
    input wire [7:0] downstream_bus_number,
    input wire [7:0] highest_bus_number,
    input wire [3:0] io_window_limit,
    input wire [3:0] io_window_base,
    input wire [7:0] cache_line_size,
    input wire [7:0] primary_latency_timer,
    input wire [7:0] secondary_latency_timer
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    reg serr_en_reg; // shadow of the error report enable
    reg int_dis_reg; // shadow of interrupt blocking, only kept in reverse mode
    // shadow the command byte so outputs are judged from the port traffic alone
    always @(posedge clk) begin
        if (!resetn) begin
            serr_en_reg <= 1'b0;
            int_dis_reg <= 1'b0;
        end else if (cfg_wr && cfg_addr == 8'h04 && cfg_be[1]) begin
            serr_en_reg <= cfg_wdata[8];
            int_dis_reg <= cfg_wdata[10] & reverse_mode;
        end
    end
    err_msg_a: assert property (err_msg_send == (!reverse_mode && fwd_err_req && serr_en_reg))
        else $error("error message output wrong");
    err_pin_a: assert property (system_error_out_n == !(reverse_mode && rev_err_req && serr_en_reg))
        else $error("system error pin wrong");
    irq_gate_a: assert property ({legacy_irq_d_n, legacy_irq_c_n, legacy_irq_b_n, legacy_irq_a_n} ==
        (core_irq_n | {4{reverse_mode && int_dis_reg}})) else $error("interrupt gating wrong");
    line_size_a: assert property (cfg_wr && cfg_addr == 8'h0C && cfg_be[0] |=>
        cache_line_size == {2'b00, $past(cfg_wdata[5:2]), 2'b00}) else $error("cache line size wrong");
    pri_lat_a: assert property (!reverse_mode |-> primary_latency_timer == 8'h00)
        else $error("primary latency timer not zero");
    sec_lat_a: assert property (reverse_mode |-> secondary_latency_timer == 8'h00)
        else $error("secondary latency timer not zero");
    io_base_a: assert property (cfg_wr && cfg_addr == 8'h1C && cfg_be[0] |=>
        io_window_base == $past(cfg_wdata[7:4])) else $error("io base not stored");
    class_rd_a: assert property (cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata_reg[31:8] == 24'h06_0400)
        else $error("class code wrong");
    cmd_fixed_a: assert property (cfg_rd && cfg_addr == 8'h04 |=> cfg_rdata_reg[20] &&
        cfg_rdata_reg[26:25] == {1'b0, $past(reverse_mode)} && !cfg_rdata_reg[9] && !cfg_rdata_reg[7])
        else $error("fixed command or status bits wrong");
    hdr_rd_a: assert property (cfg_rd && cfg_addr == 8'h0C |=> cfg_rdata_reg[31:16] ==
        {9'h000, ($past(nontransparent_mode) ? 7'h00 : 7'h01)}) else $error("header layout wrong");
    unmapped_a: assert property (cfg_rd && cfg_addr == 8'h10 |=> cfg_rdata_reg == 32'h0000_0000)
        else $error("unmapped read not zero");
    bus_num_a: assert property (cfg_wr && cfg_addr == 8'h18 && cfg_be == 4'hF |=>
        {highest_bus_number, downstream_bus_number, upstream_bus_number} ==
        $past(cfg_wdata[23:0])) else $error("bus numbers not stored");
    io_limit_a: assert property (cfg_wr && cfg_addr == 8'h1C && cfg_be[1] |=>
        io_window_limit == $past(cfg_wdata[15:12])) else $error("io limit not stored");
    // main scenarios reached
    cover property (err_msg_send);
    cover property (!system_error_out_n);
    cover property (reverse_mode && int_dis_reg && !core_irq_n[0]);
endmodule // bth_hdr_checker

// ===== tb_top.sv
// self-checking bench for the bridge type-1 header
`timescale 1ns/1ns
`include "bth_defs.vh"
module tb_top;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg rev = 1'b0, pcix = 1'b0, nt = 1'b0, act = 1'b1; // straps and write-phase level
    reg cfg_wr = 1'b0, cfg_rd = 1'b0;
    reg [7:0] cfg_addr = 8'h00;
    reg [3:0] cfg_be = 4'h0;
    reg [31:0] cfg_wdata = 32'h0000_0000;
    reg [21:0] ev = 22'h00_0000; // one line per error event, active high here
    reg [3:0] irq_n = 4'hF;
    wire [31:0] rdata;
    logic [63:0] exp_q[$]; // notes of {mask, expected} per read
    reg rd_pend_reg = 1'b0;
    integer error_cnt = 0, samples_checked = 0, i, k;
    logic [63:0] note;
    logic [4:0] ent;
    logic [7:0] a;
    logic [31:0] w, m;
    // per event: {reverse, secondary, flag bit minus 24}
    localparam logic [4:0] evt_tab [22] = '{5'h00, 5'h00, 5'h03, 5'h04, 5'h05, 5'h07, 5'h06,
        5'h10, 5'h10, 5'h13, 5'h14, 5'h15, 5'h17, 5'h16, 5'h08, 5'h08, 5'h0C, 5'h0D, 5'h1E,
        5'h10, 5'h08, 5'h0E};
    bth_config_header dut_u (
        .clk(clk), .resetn(resetn), .reverse_mode(rev), .pcix_mode(pcix),
        .nontransparent_mode(nt), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_reg(rdata),
        .fwd_pri_poison_cpl(ev[0]), .fwd_pri_poison_wr(ev[1]), .fwd_pri_ca_sent(ev[2]),
        .fwd_pri_ca_cpl(ev[3]), .fwd_pri_ur_cpl(ev[4]), .fwd_pri_poison_rx(ev[5]),
        .fwd_err_req(ev[6]), .rev_pri_rd_perr(ev[7]), .rev_pri_scm_perr(ev[8]),
        .rev_pri_ta_sent(ev[9]), .rev_pri_ta_det(ev[10]), .rev_pri_ma_det(ev[11]),
        .rev_pri_par_det(ev[12]), .rev_err_req(ev[13]), .fwd_sec_rd_perr(ev[14]),
        .fwd_sec_scm_perr(ev[15]), .fwd_sec_ta_det(ev[16]), .fwd_sec_ma_det(ev[17]),
        .rev_sec_err_msg(ev[18]), .upstream_parity_err_n(~ev[19]), .rev_pri_wr_active(act),
        .downstream_parity_err_n(~ev[20]), .fwd_sec_wr_active(act), .fwd_sec_serr_n(~ev[21]),
        .core_irq_n(irq_n), .err_msg_send(), .system_error_out_n(), .legacy_irq_a_n(),
        .legacy_irq_b_n(), .legacy_irq_c_n(), .legacy_irq_d_n(), .upstream_bus_number(),
        .downstream_bus_number(), .highest_bus_number(), .io_window_base(),
        .io_window_limit(), .cache_line_size(), .primary_latency_timer(),
        .secondary_latency_timer()
    );
    initial begin
        forever #50 clk = ~clk;
    end
    // compare and count; an unknown never matches
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // the answer lands one edge after the read, so judge it at the falling edge
    always @(posedge clk) rd_pend_reg <= cfg_rd && resetn;
    always @(negedge clk) begin
        if (rd_pend_reg) begin
            note = exp_q.pop_front();
            chk(rdata & note[63:32], note[31:0]);
        end
    end
    // one-cycle strobes; a gap edge between calls keeps each signal single-driven
    task wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, ad, be, d};
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] mk, input logic [31:0] e);
        exp_q.push_back({mk, e & mk});
        @(posedge clk);
        {cfg_rd, cfg_addr} <= {1'b1, ad};
        @(posedge clk);
        cfg_rd <= 1'b0;
    endtask
    task rdf(input logic [7:0] ad, input logic [31:0] e);
        rd(ad, 32'hFFFF_FFFF, e);
    endtask
    task pulse(input integer n);
        @(posedge clk);
        ev[n] <= 1'b1;
        irq_n <= 4'($urandom);
        @(posedge clk);
        ev[n] <= 1'b0;
    endtask
    // reset held six cycles with the given straps; access starts two edges later
    task do_reset(input logic [2:0] s);
        @(posedge clk);
        {rev, pcix, nt, resetn} <= {s, 1'b0};
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        end_sim;
    end
    initial begin
        void'($urandom(32'h0f1f));
        for (i = 0; i < 4; i = i + 1) begin
            do_reset({i[1], i[0], i[0]});
            rdf(8'h04, {16'h0010 | (i[1] ? 16'h0220 : 16'h0000) | (i == 2 ? 16'h0080 : 16'h0000),
                16'h0000});
            rdf(8'h0C, {9'h000, (i[0] ? 7'h00 : 7'h01), (i == 3 ? 8'h40 : 8'h00), 8'h00});
            rdf(8'h18, {(i == 1 ? 8'h40 : 8'h00), 24'h00_0000});
            rdf(8'h1C, {16'h0020 | (i[1] ? 16'h0000 : 16'h0200) | (i == 0 ? 16'h0080 : 16'h0000),
                16'h0101});
            w = $urandom;
            wr(8'h0C, 4'hF, w);
            wr(8'h18, 4'hF, w);
            wr(8'h1C, 4'hF, w);
            wr(8'h04, 4'h3, w);
            wr(8'h08, 4'hF, w);
            rdf(8'h0C, {9'h000, (i[0] ? 7'h00 : 7'h01), (i[1] ? w[15:8] : 8'h00), 2'b00, w[5:2],
                2'b00});
            rdf(8'h18, {(i[1] ? 8'h00 : w[31:24]), w[23:0]});
            rd(8'h1C, 32'h0000_FFFF, {16'h0000, w[15:12], 4'h1, w[7:4], 4'h1});
            rd(8'h04, 32'h0000_FFC0, {21'h00_0000, w[10] & i[1], 1'b0, w[8], 1'b0, w[6], 6'h00});
            rdf(8'h08, {24'h06_0400, `BTH_REVISION});
            rdf(8'h10, 32'h0000_0000);
            $display("strap test %0d done", i);
        end
        // still reverse here, so interrupt blocking is stored along with both enables
        wr(8'h04, 4'h3, 32'h0000_0540);
        for (i = 0; i < 22; i = i + 1) begin
            ent = evt_tab[i];
            k = 24 + ent[2:0];
            a = ent[3] ? 8'h1C : 8'h04;
            m = 32'h0000_0001 << k;
            rev <= ~ent[4];
            pulse(i);
            rd(a, m, 32'h0000_0000);
            rev <= ent[4];
            pulse(i);
            rd(a, m, m);
            wr(a, 4'h8, 32'h0000_0000);
            rd(a, m, m);
            wr(a, 4'h8, m);
            rd(a, m, 32'h0000_0000);
            $display("event test %0d done", i);
        end
        // system error off: no flag; parity input outside a write: no flag
        wr(8'h04, 4'h3, 32'h0000_0040);
        act <= 1'b0;
        rev <= 1'b1;
        pulse(13);
        pulse(19);
        rev <= 1'b0;
        pulse(6);
        pulse(20);
        // parity response off as well: a poisoned completion leaves no flag
        wr(8'h04, 4'h3, 32'h0000_0000);
        pulse(0);
        rd(8'h04, 32'h4100_0000, 32'h0000_0000);
        rd(8'h1C, 32'h0100_0000, 32'h0000_0000);
        $display("enable gating test done");
        repeat (3) @(posedge clk);
        end_sim;
    end
endmodule // tb_top
bind bth_config_header bth_hdr_checker chk_u (.clk, .resetn, .reverse_mode, .nontransparent_mode,
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_reg, .fwd_err_req, .rev_err_req,
    .core_irq_n, .err_msg_send, .system_error_out_n, .legacy_irq_a_n, .legacy_irq_b_n,
    .legacy_irq_c_n, .legacy_irq_d_n, .io_window_base, .cache_line_size, .primary_latency_timer,
    .secondary_latency_timer, .upstream_bus_number, .downstream_bus_number, .highest_bus_number,
    .io_window_limit);
